// file: rtl/asp_ctrl.sv
// Converter sequencing, power states and result formatting.
//
// Functional notes
// - Sampling ends by clearing the sample bit or by automatic sequencing.
// - Module-on high lets the module power up and run; low disables everything.
// - In sleep without the RC clock, the converter clock stops and stays low.
// - Sleep without the RC clock aborts a running conversion; it is never resumed.
// - Sleep entry and exit leave register contents unchanged.
// - RC clock keeps running in sleep; one cycle delay before converting.
// - Finished conversion sets done flag and writes result buffer.
// - Sleep conversion wakes if interrupt enabled, else powers down, on bit kept.
// - Stop-in-idle low runs through CPU idle; high halts the converter.
// - Reset clears registers except direction (set to all ones), turns module off, aborts sequences.
// - Reset leaves result buffer untouched; contents undefined after power-on.
// - Results and buffer entries are 10 bits, read as 16-bit words.
// - Two-bit format field picks one of four read formats.
// - Buffer always stores right-justified unsigned data.
// - Fractional reads left-justify; integer reads right-justify, zero-filled if unsigned, sign-extended if signed.
// - Output-configured analog pins convert the driven digital level.
// - Conversion depends on channel select and the selected pin's direction bit.
// - Port reads return zero on analog-configured pins.
// - Digital-configured pins are not converted.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
module asp_ctrl #(
    parameter int TAD_DIV = asp_pkg::TAD_DIV,
    parameter int CONV_TAD = asp_pkg::CONV_TAD
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire asp_pkg::asp_bus_s i_bus,
    output logic [asp_pkg::BUS_W-1:0] o_rdata,
    input wire logic i_sleep,
    input wire logic i_idle,
    input wire logic i_irq_enable,
    input wire logic [asp_pkg::NPIN-1:0] i_pin_digital,
    input wire logic [asp_pkg::NPIN-1:0] i_pin_out_level,
    input wire logic [asp_pkg::RES_W-1:0] i_analog_code,
    output logic o_tad_clk,
    output logic o_conv_start,
    output logic [3:0] o_conv_pin,
    output logic o_done,
    output logic o_wake
);

    logic rst_s1_r;
    logic rst_b_r;
    logic [15:0] ctrl_r;
    logic [15:0] pcfg_r;
    logic [15:0] dir_r;
    logic [7:0] chsel_r;
    logic [asp_pkg::RES_W-1:0] buf_r [asp_pkg::NBUF];
    logic [3:0] wptr_r;
    asp_pkg::asp_state_e state_r;
    logic [7:0] div_r;
    logic tad_en;
    logic [7:0] tad_cnt_r;
    logic powered_r;
    logic rc_sleep_r;
    logic wake_r;
    logic [asp_pkg::RES_W-1:0] sample_val;
    logic wr_ctrl;
    logic module_on;
    logic run_ok;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r <= rst_s1_r;
        end
    end

    // Turns a stored right-justified result into the selected bus word.
    function automatic logic [15:0] fmt_word(input logic [9:0] d, input logic [1:0] f);
        logic [15:0] w;
        w = 16'h0000;
        unique case (asp_pkg::asp_fmt_e'(f))
            asp_pkg::ASP_FMT_UINT: w = {6'h00, d};
            asp_pkg::ASP_FMT_SINT: w = {{6{d[9]}}, d};
            asp_pkg::ASP_FMT_FRAC: w = {d, 6'h00};
            asp_pkg::ASP_FMT_SFRAC: w = {d, 6'h00};
        endcase
        return w;
    endfunction : fmt_word

    assign module_on = ctrl_r[asp_pkg::CTRL_ON];
    assign wr_ctrl = i_bus.wr && i_bus.addr == asp_pkg::OFS_CTRL;
    // Runs only when on, not halted by idle, and not in sleep without RC clock.
    assign run_ok = module_on && powered_r
        && !(i_idle && ctrl_r[asp_pkg::CTRL_SIDL])
        && !(i_sleep && !ctrl_r[asp_pkg::CTRL_RC]);
    assign tad_en = run_ok && div_r == 8'(TAD_DIV - 1);

    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            div_r <= 8'h00;
            o_tad_clk <= 1'b0;
        end else if (!run_ok) begin
            div_r <= 8'h00;
            o_tad_clk <= 1'b0;
        end else begin
            div_r <= tad_en ? 8'h00 : div_r + 8'h01;
            o_tad_clk <= div_r < 8'(TAD_DIV / 2);
        end
    end

    // Registers hold across sleep; only bus writes and completion change them.
    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            ctrl_r <= asp_pkg::CTRL_RST;
            pcfg_r <= asp_pkg::PCFG_RST;
            dir_r <= asp_pkg::DIR_RST;
            chsel_r <= asp_pkg::CHSEL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= i_bus.wdata;
            end
            if (state_r == asp_pkg::ASP_CONVERT && tad_en && tad_cnt_r == 8'(CONV_TAD - 1)) begin
                ctrl_r[asp_pkg::CTRL_DONE] <= 1'b1;
                if (!wr_ctrl || i_bus.wdata[asp_pkg::CTRL_SAMPLE_CONTROL_BIT]) begin
                    ctrl_r[asp_pkg::CTRL_SAMPLE_CONTROL_BIT] <= ctrl_r[asp_pkg::CTRL_AUTO];
                end
            end
            if (i_bus.wr && i_bus.addr == asp_pkg::OFS_PCFG) begin
                pcfg_r <= i_bus.wdata;
            end
            if (i_bus.wr && i_bus.addr == asp_pkg::OFS_DIR) begin
                dir_r <= i_bus.wdata;
            end
            if (i_bus.wr && i_bus.addr == asp_pkg::OFS_CHSEL) begin
                chsel_r <= i_bus.wdata[7:0];
            end
        end
    end

    // Selected pin: analog level, or the driven digital level if set as output.
    always_comb begin
        sample_val = i_analog_code;
        if (!dir_r[chsel_r[3:0]]) begin
            sample_val = {asp_pkg::RES_W{i_pin_out_level[chsel_r[3:0]]}};
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            state_r <= asp_pkg::ASP_OFF;
            tad_cnt_r <= 8'h00;
            o_conv_start <= 1'b0;
            o_conv_pin <= 4'h0;
        end else begin
            o_conv_start <= 1'b0;
            if (!module_on || !powered_r) begin
                state_r <= asp_pkg::ASP_OFF;
                tad_cnt_r <= 8'h00;
            end else if (i_sleep && !ctrl_r[asp_pkg::CTRL_RC]) begin
                state_r <= asp_pkg::ASP_IDLE;
                tad_cnt_r <= 8'h00;
            end else if (run_ok) begin
                unique case (state_r)
                    asp_pkg::ASP_OFF: state_r <= asp_pkg::ASP_IDLE;
                    asp_pkg::ASP_IDLE: begin
                        tad_cnt_r <= 8'h00;
                        if (ctrl_r[asp_pkg::CTRL_SAMPLE_CONTROL_BIT]) begin
                            state_r <= asp_pkg::ASP_SAMPLE;
                        end
                    end
                    asp_pkg::ASP_SAMPLE: begin
                        if (tad_en && tad_cnt_r < 8'(asp_pkg::SAMPLE_TAD)) begin
                            tad_cnt_r <= tad_cnt_r + 8'h01;
                        end
                        // Manual clear or auto ends sampling, both only after the sample time.
                        if ((!ctrl_r[asp_pkg::CTRL_SAMPLE_CONTROL_BIT] || ctrl_r[asp_pkg::CTRL_AUTO])
                            && tad_cnt_r >= 8'(asp_pkg::SAMPLE_TAD)) begin
                            tad_cnt_r <= 8'h00;
                            state_r <= ctrl_r[asp_pkg::CTRL_RC] ? asp_pkg::ASP_DELAY
                                : asp_pkg::ASP_CONVERT;
                            o_conv_start <= !ctrl_r[asp_pkg::CTRL_RC];
                            o_conv_pin <= chsel_r[3:0];
                        end
                    end
                    asp_pkg::ASP_DELAY: begin
                        if (tad_cnt_r >= 8'(asp_pkg::RC_DELAY_CYC - 1)) begin
                            state_r <= asp_pkg::ASP_CONVERT;
                            o_conv_start <= 1'b1;
                            tad_cnt_r <= 8'h00;
                        end else begin
                            tad_cnt_r <= tad_cnt_r + 8'h01;
                        end
                    end
                    asp_pkg::ASP_CONVERT: begin
                        if (tad_en) begin
                            if (tad_cnt_r == 8'(CONV_TAD - 1)) begin
                                tad_cnt_r <= 8'h00;
                                state_r <= asp_pkg::ASP_IDLE;
                            end else begin
                                tad_cnt_r <= tad_cnt_r + 8'h01;
                            end
                        end
                    end
                    default: state_r <= asp_pkg::ASP_OFF;
                endcase
            end
        end
    end

    // Result buffer has no reset so device reset leaves it as it was.
    always_ff @(posedge i_clk_sys) begin
        if (run_ok && state_r == asp_pkg::ASP_CONVERT && tad_en
            && tad_cnt_r == 8'(CONV_TAD - 1)) begin
            // Digital-configured pins give zero, never a conversion.
            buf_r[wptr_r] <= pcfg_r[o_conv_pin] ? '0 : sample_val;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            wptr_r <= 4'h0;
        end else if (run_ok && state_r == asp_pkg::ASP_CONVERT && tad_en
            && tad_cnt_r == 8'(CONV_TAD - 1)) begin
            wptr_r <= wptr_r + 4'h1;
        end
    end

    // Power state: a sleep conversion without interrupt powers the module down.
    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            powered_r <= 1'b0;
            rc_sleep_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            wake_r <= 1'b0;
            rc_sleep_r <= i_sleep && state_r == asp_pkg::ASP_CONVERT;
            if (!module_on) begin
                powered_r <= 1'b0;
            end else if (wr_ctrl && i_bus.wdata[asp_pkg::CTRL_ON]) begin
                powered_r <= 1'b1;
            end else if (!powered_r && !i_sleep && module_on && !rc_sleep_r) begin
                powered_r <= 1'b1;
            end
            if (i_sleep && state_r == asp_pkg::ASP_CONVERT && tad_en
                && tad_cnt_r == 8'(CONV_TAD - 1)) begin
                if (i_irq_enable) begin
                    wake_r <= 1'b1;
                end else begin
                    powered_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            o_done <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_done <= ctrl_r[asp_pkg::CTRL_DONE];
            o_wake <= wake_r;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_r) begin
        if (!rst_b_r) begin
            o_rdata <= 16'h0000;
        end else if (i_bus.rd) begin
            o_rdata <= 16'h0000;
            if (i_bus.addr < 8'(asp_pkg::NBUF)) begin
                o_rdata <= fmt_word(buf_r[i_bus.addr[3:0]], ctrl_r[asp_pkg::CTRL_FORM +: 2]);
            end
            unique case (i_bus.addr)
                asp_pkg::OFS_CTRL: o_rdata <= ctrl_r;
                asp_pkg::OFS_STAT: o_rdata <= {12'h000, wake_r,
                    state_r == asp_pkg::ASP_CONVERT, state_r == asp_pkg::ASP_SAMPLE, powered_r};
                asp_pkg::OFS_PCFG: o_rdata <= pcfg_r;
                asp_pkg::OFS_DIR: o_rdata <= dir_r;
                asp_pkg::OFS_PORT: o_rdata <= i_pin_digital & pcfg_r;
                asp_pkg::OFS_CHSEL: o_rdata <= {8'h00, chsel_r};
                default: ;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule : asp_ctrl

// file: rtl/asp_pkg.sv
// Package with constants and carrier types for the converter control block.
package asp_pkg;

    localparam int RES_W = 10;
    localparam int BUS_W = 16;
    localparam int ADDR_W = 8;
    localparam int NBUF = 16;
    localparam int NPIN = 16;

    // Register word offsets.
    localparam logic [7:0] OFS_BUF0 = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h21;
    localparam logic [7:0] OFS_PCFG = 8'h22;
    localparam logic [7:0] OFS_DIR = 8'h23;
    localparam logic [7:0] OFS_PORT = 8'h24;
    localparam logic [7:0] OFS_CHSEL = 8'h25;

    // Control register field positions.
    localparam int CTRL_ON = 15;
    localparam int CTRL_SIDL = 13;
    localparam int CTRL_FORM = 8;
    localparam int CTRL_RC = 7;
    localparam int CTRL_AUTO = 2;
    localparam int CTRL_SAMPLE_CONTROL_BIT = 1;
    localparam int CTRL_DONE = 0;

    // Status register field positions.
    localparam int STAT_POWERED = 0;
    localparam int STAT_SAMPLING = 1;
    localparam int STAT_CONVERTING = 2;
    localparam int STAT_WAKE = 3;

    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PCFG_RST = 16'h0000;
    localparam logic [15:0] DIR_RST = 16'hffff;
    localparam logic [7:0] CHSEL_RST = 8'h00;

    // Timing: sample time in conversion clocks, conversion length, RC start delay.
    localparam int SAMPLE_TAD = 1;
    localparam int CONV_TAD = 12;
    localparam int RC_DELAY_CYC = 1;
    localparam int TAD_DIV = 4;

    typedef enum logic [1:0] {
        ASP_FMT_UINT = 2'h0,
        ASP_FMT_SINT = 2'h1,
        ASP_FMT_FRAC = 2'h2,
        ASP_FMT_SFRAC = 2'h3
    } asp_fmt_e;

    typedef enum logic [4:0] {
        ASP_OFF = 5'h01,
        ASP_IDLE = 5'h02,
        ASP_SAMPLE = 5'h04,
        ASP_DELAY = 5'h08,
        ASP_CONVERT = 5'h10
    } asp_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BUS_W-1:0] wdata;
        logic wr;
        logic rd;
    } asp_bus_s;

endpackage : asp_pkg

// file: testbench/asp_ctrl_props.sv
// Concurrent property checker for the converter control block.
`timescale 1ns/1ns
module asp_ctrl_chk #(
    parameter int TAD_DIV = 4,
    parameter int CONV_TAD = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire asp_pkg::asp_bus_s i_bus,
    input wire logic [asp_pkg::BUS_W-1:0] o_rdata,
    input wire logic i_sleep,
    input wire logic i_idle,
    input wire logic i_irq_enable,
    input wire logic o_tad_clk,
    input wire logic o_conv_start,
    input wire logic o_done,
    input wire logic o_wake
);
    localparam int CONV_MAX = TAD_DIV * (CONV_TAD + 4) + 8;
    logic [15:0] ctrl_r;
    logic [15:0] pcfg_r;
    logic rd_q;
    wire on_w = ctrl_r[asp_pkg::CTRL_ON];
    wire rc_w = ctrl_r[asp_pkg::CTRL_RC];
    wire sidl_w = ctrl_r[asp_pkg::CTRL_SIDL];
    wire [1:0] fmt_w = ctrl_r[9:8];
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= '0;
            pcfg_r <= '0;
            rd_q <= 1'b0;
        end else begin
            rd_q <= i_bus.rd;
            if (i_bus.wr && i_bus.addr == asp_pkg::OFS_CTRL) begin
                ctrl_r <= i_bus.wdata;
            end
            if (i_bus.wr && i_bus.addr == asp_pkg::OFS_PCFG) begin
                pcfg_r <= i_bus.wdata;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence seq_off; !on_w ##1 !on_w; endsequence
    sequence seq_buf_rd; i_bus.rd && i_bus.addr < 8'h10; endsequence
    off_quiet_a: assert property (seq_off |-> !o_tad_clk && !o_conv_start)
        else $error("converter active while off");
    sleep_stop_a: assert property ((i_sleep && !rc_w) [*2] |-> !o_tad_clk && !$rose(o_done))
        else $error("converter ran in sleep");
    idle_halt_a: assert property ((sidl_w && i_idle) [*2] |-> !o_tad_clk)
        else $error("converter ran in idle");
    conv_ends_a: assert property (o_conv_start |-> ##[1:CONV_MAX] ($rose(o_done) || i_sleep || i_idle || !on_w))
        else $error("conversion never finished");
    done_early_a: assert property (o_conv_start |=> (!$rose(o_done)) [*8])
        else $error("done too soon");
    wake_irq_a: assert property ($rose(o_done) && i_sleep && i_irq_enable |-> ##[0:3] o_wake)
        else $error("no wake after sleep conversion");
    wake_cause_a: assert property (o_wake |-> i_irq_enable)
        else $error("wake without interrupt enable");
    rdata_idle_a: assert property (!rd_q |-> o_rdata == 16'h0000)
        else $error("read data outside read cycle");
    port_zero_a: assert property (i_bus.rd && i_bus.addr == asp_pkg::OFS_PORT |=> (o_rdata & ~pcfg_r) == 16'h0000)
        else $error("analog pin read nonzero");
    int_fmt_a: assert property ((seq_buf_rd ##0 !fmt_w[1]) |=> o_rdata[15:10] == (fmt_w[0] ? {6{o_rdata[9]}} : 6'h00))
        else $error("integer format upper bits wrong");
    frac_fmt_a: assert property ((seq_buf_rd ##0 fmt_w[1]) |=> o_rdata[5:0] == 6'h00)
        else $error("fractional format low bits nonzero");
endmodule : asp_ctrl_chk
bind asp_ctrl asp_ctrl_chk #(.TAD_DIV(TAD_DIV), .CONV_TAD(CONV_TAD)) i_chk (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_sleep(i_sleep), .i_idle(i_idle), .i_irq_enable(i_irq_enable), .o_tad_clk(o_tad_clk),
    .o_conv_start(o_conv_start), .o_done(o_done), .o_wake(o_wake));

// file: testbench/asp_pin_model.sv
// Model of the analog pins and pin drivers feeding the converter.
`timescale 1ns/1ns
module asp_pin_model (
    input wire logic [9:0] i_level,
    input wire logic [15:0] i_drive,
    input wire logic [3:0] i_conv_pin,
    output logic [15:0] o_pin_out_level,
    output logic [9:0] o_analog_code
);
    // Each pin sees the shared level XORed with its index, so a wrong pin shows up.
    assign o_analog_code = i_level ^ {6'h00, i_conv_pin};
    assign o_pin_out_level = i_drive;
endmodule : asp_pin_model

// file: testbench/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module tb_top;
    typedef struct {
        string nm;
        logic [15:0] v;
    } asp_exp_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    asp_pkg::asp_bus_s bus = '0;
    logic sleep = 1'b0, idle = 1'b0, irq = 1'b0, rd_q = 1'b0;
    logic [15:0] pin_dig = '0, drive = '0, rnd = 16'h0004, rdata, pin_out;
    logic [9:0] level = '0, acode;
    logic [9:0] codes [16];
    logic tad, start, done, wake;
    logic wake_seen = 1'b0;
    logic [3:0] cpin;
    asp_exp_s exp_q [$];
    asp_exp_s e;
    int n_errors = 0, checks = 0, n = 0;
    always #5 clk = ~clk;
    asp_pin_model i_pins (.i_level(level), .i_drive(drive), .i_conv_pin(cpin),
        .o_pin_out_level(pin_out), .o_analog_code(acode));
    asp_ctrl i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_sleep(sleep), .i_idle(idle), .i_irq_enable(irq), .i_pin_digital(pin_dig),
        .i_pin_out_level(pin_out), .i_analog_code(acode), .o_tad_clk(tad),
        .o_conv_start(start), .o_conv_pin(cpin), .o_done(done), .o_wake(wake));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] fmtd(input logic [9:0] c, input logic [1:0] f);
        return f[1] ? {c, 6'h00} : {{6{f[0] & c[9]}}, c};
    endfunction : fmtd
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic step();
        rnd = lfsr(rnd);
        level <= rnd[9:0];
    endtask : step
    task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // A read notes its expected word; the monitor compares it a cycle later.
    task automatic op(input bit w, input logic [7:0] a, input logic [15:0] d, input string nm);
        if (!w) begin
            exp_q.push_back('{nm, d});
        end
        bus <= '{addr: a, wdata: w ? d : 16'h0000, wr: w, rd: !w};
        cyc(1);
        bus <= '0;
        cyc(1);
    endtask : op
    task automatic wait_for(input bit st);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((st ? start : done) !== 1'b1 && k < 500);
        cyc(1);
        if (k == 500) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_for
    task automatic start_conv(input logic [15:0] ctl);
        op(1, asp_pkg::OFS_CTRL, ctl | 16'h8002, "");
        cyc(16);
        op(1, asp_pkg::OFS_CTRL, ctl | 16'h8000, "");
    endtask : start_conv
    task automatic convert(input logic [15:0] ctl, input logic [9:0] c);
        codes[n] = c;
        start_conv(ctl);
        wait_for(1'b0);
        n++;
    endtask : convert
    always @(posedge clk) rd_q <= bus.rd;
    // Wake is a one-cycle pulse, so it is latched here for a later compare.
    always @(posedge clk) begin
        if (wake === 1'b1) begin
            wake_seen <= 1'b1;
        end
    end
    always @(negedge clk) begin
        if (rd_q === 1'b1) begin
            e = exp_q.pop_front();
            cmp(e.nm, e.v, rdata);
        end
    end
    initial begin
        cyc(10);
        rst_b <= 1'b1;
        cyc(3);
        op(0, asp_pkg::OFS_CTRL, 16'h0000, "ctrl");
        op(0, asp_pkg::OFS_DIR, 16'hffff, "dir");
        op(0, 8'h30, 16'h0000, "unmapped");
        for (int i = 0; i < 6; i++) begin
            step();
            drive <= {15'h0000, i == 5};
            op(1, asp_pkg::OFS_PCFG, {15'h0000, i == 4}, "");
            op(1, asp_pkg::OFS_DIR, {15'h7fff, i != 5}, "");
            convert({6'h00, 2'(i), 8'h00}, i < 4 ? rnd[9:0] : {10{i == 5}});
            op(0, 8'(n - 1), fmtd(codes[n - 1], 2'(i)), "result");
            cmp("conv_pin", 16'h0000, {12'h000, cpin});
        end
        step();
        pin_dig <= rnd;
        op(1, asp_pkg::OFS_PCFG, 16'h00ff, "");
        op(0, asp_pkg::OFS_PORT, rnd & 16'h00ff, "port");
        op(1, asp_pkg::OFS_PCFG, 16'h0000, "");
        op(1, asp_pkg::OFS_DIR, 16'hffff, "");
        start_conv(16'h0000);
        wait_for(1'b1);
        cyc(4);
        sleep <= 1'b1;
        cyc(4);
        @(negedge clk);
        cmp("tad_clk", 16'h0000, {15'h0000, tad});
        cyc(100);
        sleep <= 1'b0;
        cyc(100);
        @(negedge clk);
        cmp("done", 16'h0000, {15'h0000, done});
        op(0, asp_pkg::OFS_CTRL, 16'h8000, "ctrl");
        irq <= 1'b1;
        sleep <= 1'b1;
        step();
        convert(16'h0080, rnd[9:0]);
        cyc(8);
        cmp("wake", 16'h0001, {15'h0000, wake_seen});
        irq <= 1'b0;
        step();
        convert(16'h0080, rnd[9:0]);
        op(0, asp_pkg::OFS_STAT, 16'h0000, "stat");
        op(0, asp_pkg::OFS_CTRL, 16'h8081, "ctrl");
        sleep <= 1'b0;
        op(0, 8'(n - 1), {6'h00, codes[n - 1]}, "result");
        op(1, asp_pkg::OFS_CTRL, 16'ha000, "");
        idle <= 1'b1;
        cyc(10);
        @(negedge clk);
        cmp("tad_clk", 16'h0000, {15'h0000, tad});
        step();
        convert(16'h0000, rnd[9:0]);
        idle <= 1'b0;
        start_conv(16'h0000);
        wait_for(1'b1);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cyc(3);
        op(0, asp_pkg::OFS_CTRL, 16'h0000, "ctrl");
        op(0, 8'h00, {6'h00, codes[0]}, "result");
        cyc(60);
        @(negedge clk);
        cmp("done", 16'h0000, {15'h0000, done});
        end_sim();
    end
endmodule : tb_top
